// [rtl/scmw_console.sv]
// Purpose: serial console sequencer, mode switch and host watchdog
// Assumes: bytes arrive and leave through an outside serial shifter
// Notes: transmit bytes pass through a small FIFO before the shifter
//
// Functional notes
// - identification prompt first after every reset
// - analog/radio mode streams telemetry continuously
// - serial mode sends OK, then accepts commands
// - host commands honoured only in serial mode
// - in serial mode, one second silence stops motors, sends W
// - ten carriage returns force serial mode
// - command, power values clamped to range; current passed as is
`include "scmw_defines.svh"
`default_nettype none

// transmit buffer between sequencer and serial shifter
module scmw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SCMW_FIFO_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic in_valid, // byte offered
  output logic in_ready, // room for a byte
  input wire logic [WIDTH-1:0] in_data, // byte in
  output logic out_valid, // byte waiting
  input wire logic out_ready, // drain takes byte
  output logic [WIDTH-1:0] out_data // oldest byte
);
  localparam int AW = $clog2(DEPTH);
  // refuse depths that the wrapping pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [AW:0] wr_q, wr_d, rd_q, rd_d; // pointers with wrap bit
  logic do_wr, do_rd; // transfer strobes

  // flags and pointer advance
  always_comb begin
    in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    out_valid = (wr_q != rd_q);
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wr_d = do_wr ? wr_q + 1'b1 : wr_q;
    rd_d = do_rd ? rd_q + 1'b1 : rd_q;
    out_data = mem_q[rd_q[AW-1:0]];
  end

  // register pointers and storage
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (do_wr) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// console top
module scmw_console #(
  parameter int WDOG_CYCLES = `SCMW_WDOG_MS * `SCMW_CLK_MHZ * 1000,
  parameter logic [7:0] FW_REV = 8'h01, // arbitrary value
  parameter logic [15:0] FW_DATE = 16'h0101, // arbitrary value
  parameter int FIFO_DEPTH = `SCMW_FIFO_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic [1:0] cfg_mode, // command mode strap, caught at reset
  input wire logic wdog_en, // watchdog enable
  input wire logic rx_valid, // received character strobe
  input wire logic [7:0] rx_data, // received character
  input wire scmw_pkg::scmw_tele_type tele_in, // live values
  output logic tx_valid, // character for shifter
  input wire logic tx_ready, // shifter takes character
  output logic [7:0] tx_data, // character out
  output logic cmd_valid, // accepted host character
  output logic [7:0] cmd_data, // accepted character value
  output logic motor_stop, // watchdog stop pulse
  output logic serial_mode // serial command mode active
);
  localparam int WDW = $clog2(WDOG_CYCLES + 1);
  localparam logic [WDW-1:0] WD_LAST = WDW'(WDOG_CYCLES - 1);
  // refuse a watchdog count that leaves no silent cycle to count
  if (WDOG_CYCLES < 2) begin : g_bad_wdog
    $error("watchdog count too small");
  end

  scmw_pkg::scmw_state_type st_q, st_d; // sequencer state
  logic [2:0] idx_q, idx_d; // byte index in message
  logic serial_q, serial_d; // serial command mode
  logic force_q, force_d; // switch requested by carriage returns
  logic [3:0] cr_q, cr_d; // consecutive carriage returns
  logic [WDW-1:0] wd_q, wd_d; // silence counter
  scmw_pkg::scmw_tele_type tele_q, tele_d; // sampled telemetry
  logic cmdv_q, cmdv_d; // accepted character strobe
  logic [7:0] cmdd_q, cmdd_d; // accepted character
  logic stop_q, stop_d; // motor stop pulse
  logic push_v, push_r; // fifo write handshake
  logic [7:0] push_b; // fifo write byte
  logic first_q, first_d; // no byte pushed since reset
  logic timeout; // watchdog expiry

  // clamp command to -127..+127
  function automatic logic [7:0] sat_cmd(input logic [7:0] x);
    sat_cmd = (x == `SCMW_CMD_NEG) ? `SCMW_CMD_MIN : x;
  endfunction
  // clamp power to 0..127
  function automatic logic [7:0] sat_pwr(input logic [7:0] x);
    sat_pwr = (x > `SCMW_PWR_MAX) ? `SCMW_PWR_MAX : x;
  endfunction

  // sequencer: chooses the next byte and the next state
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    push_v = 1'b0;
    push_b = '0;
    timeout = wdog_en && (wd_q == WD_LAST) && !rx_valid;
    case (st_q)
      scmw_pkg::ST_ID: begin
        push_v = 1'b1;
        case (idx_q)
          3'h0: push_b = `SCMW_CH_ID;
          3'h1: push_b = FW_REV;
          3'h2: push_b = FW_DATE[15:8];
          3'h3: push_b = FW_DATE[7:0];
          default: push_b = `SCMW_CH_CR;
        endcase
        if (push_r) begin
          if (idx_q == `SCMW_ID_LAST) begin
            idx_d = '0;
            st_d = (serial_q || force_q) ? scmw_pkg::ST_OK : scmw_pkg::ST_TELE;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      scmw_pkg::ST_OK: begin
        push_v = 1'b1;
        case (idx_q)
          3'h0: push_b = `SCMW_CH_O;
          3'h1: push_b = `SCMW_CH_K;
          default: push_b = `SCMW_CH_CR;
        endcase
        if (push_r) begin
          if (idx_q == `SCMW_OK_LAST) begin
            idx_d = '0;
            st_d = scmw_pkg::ST_IDLE;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      scmw_pkg::ST_TELE: begin
        push_v = 1'b1;
        case (idx_q)
          3'h0: push_b = `SCMW_CH_FRM;
          3'h1: push_b = tele_q.cmd1;
          3'h2: push_b = tele_q.cmd2;
          3'h3: push_b = tele_q.pwr1;
          3'h4: push_b = tele_q.pwr2;
          3'h5: push_b = tele_q.amp1;
          3'h6: push_b = tele_q.amp2;
          default: push_b = `SCMW_CH_CR;
        endcase
        if (push_r) begin
          if (idx_q == `SCMW_TELE_LAST) begin
            idx_d = '0;
            st_d = force_q ? scmw_pkg::ST_OK : scmw_pkg::ST_TELE;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      scmw_pkg::ST_IDLE: begin // waiting for host traffic
        if (timeout) begin
          st_d = scmw_pkg::ST_WDOG;
        end
      end
      scmw_pkg::ST_WDOG: begin // report the expiry
        push_v = 1'b1;
        push_b = `SCMW_CH_W;
        if (push_r) begin
          st_d = scmw_pkg::ST_IDLE;
        end
      end
      default: begin // unused codes fall back to idle
        st_d = scmw_pkg::ST_IDLE;
      end
    endcase
  end

  // mode, watchdog, host input and telemetry sampling
  always_comb begin
    serial_d = serial_q || (st_d == scmw_pkg::ST_OK);
    force_d = force_q;
    cr_d = cr_q;
    if (serial_q || force_q) begin
      cr_d = '0;
    end else if (rx_valid) begin
      if (rx_data == `SCMW_CH_CR) begin
        cr_d = cr_q + 4'h1;
        if (cr_q == `SCMW_CR_COUNT - 4'h1) begin
          force_d = 1'b1;
        end
      end else begin
        cr_d = '0;
      end
    end
    if (rx_valid || st_q != scmw_pkg::ST_IDLE || !wdog_en) begin
      wd_d = '0;
    end else if (timeout) begin
      wd_d = '0;
    end else begin
      wd_d = wd_q + 1'b1;
    end
    first_d = first_q && !(push_v && push_r);
    stop_d = (st_q == scmw_pkg::ST_IDLE) && timeout;
    cmdv_d = rx_valid && serial_q;
    cmdd_d = rx_valid ? rx_data : cmdd_q;
    tele_d = tele_q;
    if (st_q == scmw_pkg::ST_TELE && idx_q == 3'h0 && push_r) begin
      tele_d.cmd1 = sat_cmd(tele_in.cmd1);
      tele_d.cmd2 = sat_cmd(tele_in.cmd2);
      tele_d.pwr1 = sat_pwr(tele_in.pwr1);
      tele_d.pwr2 = sat_pwr(tele_in.pwr2);
      tele_d.amp1 = tele_in.amp1;
      tele_d.amp2 = tele_in.amp2;
    end
  end

  // register all state; the mode strap is caught while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= scmw_pkg::ST_ID;
      idx_q <= '0;
      serial_q <= (cfg_mode == `SCMW_MODE_SERIAL);
      force_q <= 1'b0;
      cr_q <= '0;
      wd_q <= '0;
      tele_q <= '0;
      cmdv_q <= 1'b0;
      cmdd_q <= '0;
      stop_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      serial_q <= serial_d;
      force_q <= force_d;
      cr_q <= cr_d;
      wd_q <= wd_d;
      tele_q <= tele_d;
      cmdv_q <= cmdv_d;
      cmdd_q <= cmdd_d;
      stop_q <= stop_d;
      first_q <= first_d;
    end
  end

  // transmit buffer stalls the sequencer when full
  scmw_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk(clk),
    .rst(rst),
    .in_valid(push_v),
    .in_ready(push_r),
    .in_data(push_b),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  assign cmd_valid = cmdv_q;
  assign cmd_data = cmdd_q;
  assign motor_stop = stop_q;
  assign serial_mode = serial_q;

  a_id_first: assert property (@(posedge clk) disable iff (rst)
    (first_q && push_v && push_r) |-> (push_b == `SCMW_CH_ID && st_q == scmw_pkg::ST_ID))
    else $error("first byte after reset is not the identification prompt");
  a_tele_mode: assert property (@(posedge clk) disable iff (rst)
    (st_q == scmw_pkg::ST_TELE) |-> !serial_q)
    else $error("telemetry sent in serial command mode");
  a_ok_to_idle: assert property (@(posedge clk) disable iff (rst)
    (st_q == scmw_pkg::ST_OK && idx_q == `SCMW_OK_LAST && push_r)
      |=> (st_q == scmw_pkg::ST_IDLE && serial_q))
    else $error("ok prompt did not lead to command acceptance");
  a_cmd_gate: assert property (@(posedge clk) disable iff (rst)
    cmd_valid |-> ($past(rx_valid) && $past(serial_q) && cmd_data == $past(rx_data)))
    else $error("host character accepted outside serial mode");
  a_wdog_stop: assert property (@(posedge clk) disable iff (rst)
    (st_q == scmw_pkg::ST_IDLE && timeout) |=> (motor_stop && st_q == scmw_pkg::ST_WDOG))
    else $error("watchdog expiry did not stop motors");
  a_wdog_char: assert property (@(posedge clk) disable iff (rst)
    (st_q == scmw_pkg::ST_WDOG) |-> (push_v && push_b == `SCMW_CH_W))
    else $error("watchdog expiry character is not W");
  a_cr_force: assert property (@(posedge clk) disable iff (rst)
    (!serial_q && !force_q && cr_q == `SCMW_CR_COUNT - 4'h1 && rx_valid
      && rx_data == `SCMW_CH_CR) |=> force_q ##[1:20] serial_q)
    else $error("ten carriage returns did not force serial mode");
  a_tele_clamp: assert property (@(posedge clk) disable iff (rst)
    (tele_q.cmd1 != `SCMW_CMD_NEG && tele_q.cmd2 != `SCMW_CMD_NEG
      && tele_q.pwr1 <= `SCMW_PWR_MAX && tele_q.pwr2 <= `SCMW_PWR_MAX))
    else $error("telemetry value out of range");
  a_wdog_restart: assert property (@(posedge clk) disable iff (rst)
    rx_valid |=> (wd_q == '0))
    else $error("received character did not restart the watchdog");
endmodule
`default_nettype wire

// [rtl/scmw_defines.svh]
// Purpose: named constants of the serial console block
// Assumes: 8-bit characters, 50 MHz system clock
// Notes: included by the console file
`ifndef SCMW_DEFINES_SVH
`define SCMW_DEFINES_SVH
`define SCMW_CLK_MHZ 50
`define SCMW_WDOG_MS 1000
`define SCMW_CR_COUNT 4'hA
`define SCMW_CH_CR 8'h0D
`define SCMW_CH_W 8'h57
`define SCMW_CH_O 8'h4F
`define SCMW_CH_K 8'h4B
`define SCMW_CH_ID 8'h56
`define SCMW_CH_FRM 8'h3A
`define SCMW_ID_LAST 3'h4
`define SCMW_OK_LAST 3'h2
`define SCMW_TELE_LAST 3'h7
`define SCMW_CMD_NEG 8'h80
`define SCMW_CMD_MIN 8'h81
`define SCMW_PWR_MAX 8'h7F
`define SCMW_MODE_SERIAL 2'h0
`define SCMW_FIFO_DEPTH 16
`endif

// [rtl/scmw_pkg.sv]
// Purpose: shared types of the serial console block
// Assumes: nothing beyond the defines header
// Notes: constants stay in the header, types live here
`default_nettype none
package scmw_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_ID = 3'b000,
    ST_OK = 3'b001,
    ST_TELE = 3'b010,
    ST_IDLE = 3'b011,
    ST_WDOG = 3'b100
  } scmw_state_type;
  // live operating values reported in telemetry
  typedef struct packed {
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic [7:0] pwr1;
    logic [7:0] pwr2;
    logic [7:0] amp1;
    logic [7:0] amp2;
  } scmw_tele_type;
endpackage
`default_nettype wire

// [tb/scmw_host_model.sv]
// Purpose: host side of the console link, drains transmit and sends characters
// Assumes: one character per rx_valid pulse, inputs change at the falling edge
// Notes: ready drops at random to act as a slow shifter; idle rx_data shows ~last
`default_nettype none
module scmw_host_model (
  input wire logic clk, // system clock
  input wire logic stall, // hold the shifter off
  output logic tx_ready, // shifter takes a byte
  output logic rx_valid, // character strobe
  output logic [7:0] rx_data // character
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // ready about three cycles in four, never while stalled
  always @(negedge clk) begin
    tx_ready <= !stall && ($urandom_range(3) != 0);
  end
  // one strobe per character; the line then shows the inverted character
  task automatic send(input logic [7:0] ch);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = ch;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~ch;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench of the serial console sequencer
// Assumes: short watchdog count, host model on the far side
// Notes: transmitted bytes and accepted characters are queued by monitors
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WD = 20; // shortened watchdog count
  localparam logic [7:0] REV = 8'hA5; // arbitrary value
  localparam logic [15:0] DAT = 16'h1234; // arbitrary value
  logic clk, rst, wdog_en, stall, tx_valid, tx_ready, rx_valid, cmd_valid, motor_stop;
  logic serial_mode;
  logic [1:0] cfg_mode;
  logic [7:0] rx_data, tx_data, cmd_data;
  scmw_pkg::scmw_tele_type tele; // live values
  logic [7:0] txq[$]; // bytes the host took
  logic [7:0] cmdq[$]; // characters accepted
  int miscompares, num_checks, stops;
  scmw_console #(.WDOG_CYCLES(WD), .FW_REV(REV), .FW_DATE(DAT), .FIFO_DEPTH(16)) uut (
    .clk(clk), .rst(rst), .cfg_mode(cfg_mode), .wdog_en(wdog_en), .rx_valid(rx_valid),
    .rx_data(rx_data), .tele_in(tele), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .motor_stop(motor_stop), .serial_mode(serial_mode));
  scmw_host_model host (.clk(clk), .stall(stall), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // monitors of the transmit stream, accepted characters and stop pulses
  always @(posedge clk) begin
    if (!rst && tx_valid && tx_ready) txq.push_back(tx_data);
    if (!rst && cmd_valid) cmdq.push_back(cmd_data);
    if (!rst && motor_stop) stops++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // waits a bounded time for the next transmitted byte
  task automatic next_byte(input logic [7:0] exp);
    int n;
    n = 0;
    while (txq.size() == 0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(txq.size() != 0 ? txq.pop_front() : 8'hXX, exp);
  endtask
  // telemetry frame byte i with the reporting ranges applied
  function automatic logic [7:0] fb(int i, scmw_pkg::scmw_tele_type t);
    case (i)
      0: return 8'h3A;
      1: return (t.cmd1 == 8'h80) ? 8'h81 : t.cmd1;
      2: return (t.cmd2 == 8'h80) ? 8'h81 : t.cmd2;
      3: return (t.pwr1 > 8'h7F) ? 8'h7F : t.pwr1;
      4: return (t.pwr2 > 8'h7F) ? 8'h7F : t.pwr2;
      5: return t.amp1;
      6: return t.amp2;
      default: return 8'h0D;
    endcase
  endfunction
  task automatic expect_id();
    logic [7:0] e[5];
    e = '{8'h56, REV, DAT[15:8], DAT[7:0], 8'h0D};
    foreach (e[i]) next_byte(e[i]);
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(negedge clk);
    rst = 1'b1;
    cfg_mode = m;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    txq.delete();
    cmdq.delete();
    stops = 0;
  endtask
  initial begin
    logic [7:0] c;
    int n;
    rst = 1'b1;
    cfg_mode = 2'h0;
    wdog_en = 1'b0;
    stall = 1'b0;
    tele = '0;
    miscompares = 0;
    num_checks = 0;
    stops = 0;
    void'($urandom(32'hC4DE9035));
    // serial mode: identification, then the OK prompt
    do_reset(2'h0);
    expect_id();
    next_byte(8'h4F);
    next_byte(8'h4B);
    next_byte(8'h0D);
    check(8'(serial_mode), 8'h01);
    // random host characters are handed on one cycle later
    for (int i = 0; i < 8; i++) begin
      c = 8'($urandom);
      host.send(c);
      check(8'(cmd_valid), 8'h01);
      check(cmd_data, c);
    end
    // with the watchdog off, silence stops nothing
    repeat (WD + 4) @(negedge clk);
    check(8'(stops), 8'h00);
    // nulls keep the watchdog quiet, then silence trips it once
    wdog_en = 1'b1;
    repeat (8) begin
      host.send(8'h00);
      repeat (12) @(negedge clk);
    end
    check(8'(stops), 8'h00);
    check(8'(txq.size()), 8'h00);
    repeat (WD + 4) @(negedge clk);
    check(8'(stops), 8'h01);
    next_byte(8'h57);
    wdog_en = 1'b0;
    // radio mode with corner values and a full buffer held back
    tele = {8'h80, 8'($urandom), 8'hFF, 8'($urandom_range(127)), 8'h00, 8'hFF};
    stall = 1'b1;
    do_reset(2'($urandom_range(3, 1))); // any nonzero strap is radio/analog
    repeat (100) @(negedge clk);
    check(8'(tx_valid), 8'h01);
    check(tx_data, 8'h56);
    stall = 1'b0;
    expect_id();
    for (int i = 0; i < 16; i++) next_byte(fb(i % 8, tele));
    // host characters ignored; nine returns and a letter do not switch
    repeat (9) host.send(8'h0D);
    host.send(8'h41);
    repeat (100) @(negedge clk);
    check(8'(cmdq.size()), 8'h00);
    check(8'(serial_mode), 8'h00);
    repeat (10) host.send(8'h0D);
    n = 0;
    while (serial_mode !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (60) @(negedge clk);
    n = txq.size();
    check(txq[n-3], 8'h4F);
    check(txq[n-2], 8'h4B);
    check(txq[n-1], 8'h0D);
    check(8'((n - 3) % 8), 8'h00);
    check(8'(serial_mode), 8'h01);
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // cut a hang short well past the expected run length
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
